// [ssp_top.sv]
// Serial slave port, reset pin, multiplexed, interrupt and general outputs
`timescale 1ns/1ps
module ssp_top
    import ssp_pkg::*;
(
    // Core clock and reset
    input  wire logic          ref_clk_i,
    input  wire logic          rstn_i,
    // Device reset pin
    input  wire logic          chip_clear_in_n_i,
    // Serial pins
    input  wire logic          sclk_i,
    input  wire logic          ss_n_i,
    input  wire logic          mosi_i,
    output logic               mosi_o,
    output logic               mosi_oe_o,
    output logic               miso_o,
    output logic               miso_oe_o,
    // Control byte writes
    input  wire logic [7:0]    wdata_i,
    input  wire logic          pin_ctl_we_i,
    input  wire logic          link_ctl_we_i,
    input  wire logic          cpu_ctl_we_i,
    input  wire logic          mode_we_i,
    input  wire logic          gpout_we_i,
    // Control readback
    output ssp_pin_ctl_s       pin_control_o,
    output logic      [7:0]    bus_link_control_o,
    output logic               chip_clear_active_o,
    // Internal signal sources
    input  wire logic          irq_request_i,
    input  ssp_mux_src_s       mux_src_i,
    // Pin outputs
    output logic               multiplexed_out_o,
    output logic               irq_o,
    output logic               irq_oe_o,
    output logic      [7:0]    general_outputs_o,
    // Received byte stream
    output logic      [7:0]    rx_data_o,
    output logic               rx_valid_o,
    input  wire logic          rx_ready_i,
    output logic               rx_overrun_o,
    // Transmit byte stream
    input  ssp_tx_word_s       tx_word_i,
    input  wire logic          tx_valid_i,
    output logic               tx_ready_o
);

    // ========================================================================
    // Reset pin synchroniser
    logic clr_s1;
    logic clr_s2;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clr_s1 <= 1'b0;
            clr_s2 <= 1'b0;
        end else begin
            clr_s1 <= ~chip_clear_in_n_i;
            clr_s2 <= clr_s1;
        end
    end

    wire chip_clear = clr_s2;

    // ========================================================================
    // Control bytes
    logic [7:0] pin_control_reg;
    logic [7:0] bus_link_control_reg;
    logic [7:0] host_cpu_control_reg;
    logic [7:0] mode_reg;
    logic [7:0] gpout_reg;

    // Pin and link control survive the reset pin, only core reset clears them
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_control_reg      <= PIN_CTL_RST;
            bus_link_control_reg <= LINK_CTL_RST;
        end else begin
            if (pin_ctl_we_i) begin
                pin_control_reg <= wdata_i;
            end
            if (link_ctl_we_i) begin
                bus_link_control_reg <= wdata_i;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            host_cpu_control_reg <= CPU_CTL_RST;
            mode_reg             <= MODE_RST;
            gpout_reg            <= GPOUT_RST;
        end else if (chip_clear) begin
            host_cpu_control_reg <= CPU_CTL_RST;
            mode_reg             <= MODE_RST;
            gpout_reg            <= GPOUT_RST;
        end else begin
            if (cpu_ctl_we_i) begin
                host_cpu_control_reg <= wdata_i;
            end
            if (mode_we_i) begin
                mode_reg <= wdata_i;
            end
            if (gpout_we_i) begin
                gpout_reg <= wdata_i;
            end
        end
    end

    ssp_pin_ctl_s pin_ctl;
    assign pin_ctl.half_duplex   = pin_control_reg[HALF_DUPLEX_BIT];
    assign pin_ctl.irq_edge_mode = pin_control_reg[IRQ_EDGE_BIT];
    assign pin_ctl.irq_polarity  = pin_control_reg[IRQ_POL_BIT];
    assign pin_ctl.mux_select_hi = pin_control_reg[MUX_HI_BIT];
    assign pin_ctl.mux_select_lo = pin_control_reg[MUX_LO_BIT];

    wire irq_pin_enable         = host_cpu_control_reg[IRQ_PIN_EN_BIT];
    wire split_interrupt_select = mode_reg[SPLIT_IRQ_BIT];

    // ========================================================================
    // Multiplexed output select
    ssp_mux_sel_e mux_sel;
    assign mux_sel = ssp_mux_sel_e'({pin_ctl.mux_select_hi,
                                     pin_ctl.mux_select_lo});

    logic next_mux_out;
    always_comb begin
        next_mux_out = 1'b0;
        if (split_interrupt_select) begin
            next_mux_out = mux_src_i.src[4];
        end else begin
            case (mux_sel)
                SSP_MUX_SRC0: next_mux_out = mux_src_i.src[0];
                SSP_MUX_SRC1: next_mux_out = mux_src_i.src[1];
                SSP_MUX_SRC2: next_mux_out = mux_src_i.src[2];
                SSP_MUX_SRC3: next_mux_out = mux_src_i.src[3];
                default:      next_mux_out = 1'b0;
            endcase
        end
    end

    // ========================================================================
    // Interrupt pin
    wire irq_active = irq_pin_enable && irq_request_i;
    wire next_irq_o = pin_ctl.irq_edge_mode ?
                      (irq_active ~^ pin_ctl.irq_polarity) :
                      1'b0;
    wire next_irq_oe = pin_ctl.irq_edge_mode ? 1'b1 : irq_active;

    // ========================================================================
    // Registered pin and status outputs
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            multiplexed_out_o   <= 1'b0;
            irq_o               <= 1'b0;
            irq_oe_o            <= 1'b0;
            general_outputs_o   <= GPOUT_RST;
            pin_control_o       <= '0;
            bus_link_control_o  <= LINK_CTL_RST;
            chip_clear_active_o <= 1'b0;
        end else begin
            multiplexed_out_o   <= next_mux_out;
            irq_o               <= next_irq_o;
            irq_oe_o            <= next_irq_oe;
            general_outputs_o   <= gpout_reg;
            pin_control_o       <= pin_ctl;
            bus_link_control_o  <= bus_link_control_reg;
            chip_clear_active_o <= chip_clear;
        end
    end

    // ========================================================================
    // Serial clock domain
    // Select high holds the frame logic in reset, so clock edges outside a
    // frame cannot move it and any partial byte is thrown away.
    wire spi_rst_n = rstn_i && !ss_n_i;

    logic [2:0]   bit_cnt;
    logic [7:0]   rx_shift;
    ssp_tx_word_s tx_cur;
    logic [7:0]   rx_hold;
    logic         rx_tog;
    logic         take_tog;
    logic         started;
    logic         out_bit;
    logic         out_oe;
    ssp_tx_word_s tx_reg;

    wire [7:0] rx_next = {rx_shift[6:0], mosi_i};
    wire       byte_end = (bit_cnt == LAST_BIT);
    wire       byte_beg = (bit_cnt == BIT_CNT_RST);

    always_ff @(posedge sclk_i or negedge spi_rst_n) begin
        if (!spi_rst_n) begin
            bit_cnt  <= BIT_CNT_RST;
            rx_shift <= '0;
            tx_cur   <= '0;
        end else begin
            bit_cnt  <= bit_cnt + 3'h1;
            rx_shift <= rx_next;
            if (byte_beg) begin
                tx_cur <= tx_reg;
            end
        end
    end

    // Complete bytes and load requests outlive the frame reset on purpose
    always_ff @(posedge sclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_hold  <= '0;
            rx_tog   <= 1'b0;
            take_tog <= 1'b0;
        end else begin
            if (byte_end && !ss_n_i) begin
                rx_hold <= rx_next;
                rx_tog  <= ~rx_tog;
            end
            if (byte_beg && !ss_n_i) begin
                take_tog <= ~take_tog;
            end
        end
    end

    // Next bit launched on the falling edge, master samples it on the rise
    always_ff @(negedge sclk_i or negedge spi_rst_n) begin
        if (!spi_rst_n) begin
            started <= 1'b0;
            out_bit <= 1'b0;
            out_oe  <= 1'b0;
        end else begin
            started <= 1'b1;
            if (byte_beg) begin
                out_bit <= tx_reg.data[7];
                out_oe  <= tx_reg.drive;
            end else begin
                out_bit <= tx_cur.data[~bit_cnt];
                out_oe  <= tx_cur.drive;
            end
        end
    end

    // Before the first falling edge the first bit comes from the load reg
    wire serial_bit = started ? out_bit : tx_reg.data[7];
    wire first_oe   = started ? out_oe : tx_reg.drive;

    assign miso_o    = serial_bit;
    assign miso_oe_o = !ss_n_i && !pin_ctl.half_duplex;
    assign mosi_o    = serial_bit;
    assign mosi_oe_o = !ss_n_i && pin_ctl.half_duplex && first_oe;

    // ========================================================================
    // Toggle crossings into the core domain
    // Two stages let the level settle, the third spots the toggle
    logic [SYNC_STAGES:0] rx_sync;
    logic [SYNC_STAGES:0] take_sync;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_sync   <= '0;
            take_sync <= '0;
        end else begin
            rx_sync   <= {rx_sync[SYNC_STAGES-1:0], rx_tog};
            take_sync <= {take_sync[SYNC_STAGES-1:0], take_tog};
        end
    end

    // A change between the last two stages is one event in the core
    function automatic logic toggled(input logic [SYNC_STAGES:0] s);
        return s[SYNC_STAGES] ^ s[SYNC_STAGES-1];
    endfunction : toggled

    wire rx_event   = toggled(rx_sync);
    wire take_event = toggled(take_sync);

    // ========================================================================
    // Receive buffer; the master cannot be stalled, so a full buffer drops
    logic buf_ready;

    ssp_buf2 #(
        .WIDTH (8),
        .DEPTH (2)
    ) u_rx_buf (
        .clk_i       (ref_clk_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (rx_event),
        .in_ready_o  (buf_ready),
        .in_data_i   (rx_hold),
        .out_valid_o (rx_valid_o),
        .out_ready_i (rx_ready_i),
        .out_data_o  (rx_data_o)
    );

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_overrun_o <= 1'b0;
        end else begin
            rx_overrun_o <= rx_event && !buf_ready;
        end
    end

    // ========================================================================
    // Transmit load register, one byte ahead of the serial side
    logic tx_loaded;
    wire  tx_accept = tx_valid_i && !tx_loaded;

    // Ready keeps a flop of its own so the port never shows a gate
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_reg     <= '{drive: 1'b0, data: TX_IDLE_BYTE};
            tx_loaded  <= 1'b0;
            tx_ready_o <= 1'b1;
        end else if (tx_accept) begin
            tx_reg     <= tx_word_i;
            tx_loaded  <= 1'b1;
            tx_ready_o <= 1'b0;
        end else if (take_event) begin
            tx_loaded  <= 1'b0;
            tx_ready_o <= 1'b1;
        end
    end

    // Byte taken with nothing pending leaves the last word in place; the
    // serial side then repeats it rather than sending a torn value.

endmodule : ssp_top

// [ssp_pkg.sv]
// Shared constants and carriers of the serial slave port and pin logic
package ssp_pkg;

    // ========================================================================
    // Field positions of the pin control byte
    localparam int MUX_LO_BIT      = 0;
    localparam int MUX_HI_BIT      = 1;
    localparam int IRQ_POL_BIT     = 2;
    localparam int IRQ_EDGE_BIT    = 3;
    localparam int HALF_DUPLEX_BIT = 4;

    // ========================================================================
    // Field positions of the other control bytes
    localparam int IRQ_PIN_EN_BIT  = 0;
    localparam int SPLIT_IRQ_BIT   = 0;

    // ========================================================================
    // Reset values
    localparam logic [7:0] PIN_CTL_RST  = 8'h00;
    localparam logic [7:0] LINK_CTL_RST = 8'h00;
    localparam logic [7:0] CPU_CTL_RST  = 8'h00;
    localparam logic [7:0] MODE_RST     = 8'h00;
    localparam logic [7:0] GPOUT_RST    = 8'h00;
    localparam logic [7:0] TX_IDLE_BYTE = 8'hff;
    localparam logic [2:0] BIT_CNT_RST  = 3'h0;
    localparam logic [2:0] LAST_BIT     = 3'h7;

    // ========================================================================
    // Timing: fastest serial clock against the 250 MHz core clock
    localparam int SCLK_MAX_MHZ    = 26;
    localparam int REF_CLK_MHZ     = 250;
    localparam int SYNC_STAGES     = 2;
    localparam int SCLK_MIN_CYCLES = (REF_CLK_MHZ + SCLK_MAX_MHZ - 1)
                                     / SCLK_MAX_MHZ;

    // ========================================================================
    // Multiplexed output choices
    typedef enum logic [1:0] {
        SSP_MUX_SRC0,
        SSP_MUX_SRC1,
        SSP_MUX_SRC2,
        SSP_MUX_SRC3
    } ssp_mux_sel_e;

    // ========================================================================
    // Carriers
    typedef struct packed {
        logic       drive;
        logic [7:0] data;
    } ssp_tx_word_s;

    typedef struct packed {
        logic half_duplex;
        logic irq_edge_mode;
        logic irq_polarity;
        logic mux_select_hi;
        logic mux_select_lo;
    } ssp_pin_ctl_s;

    typedef struct packed {
        logic [4:0] src;
    } ssp_mux_src_s;

endpackage : ssp_pkg

// [ssp_buf2.sv]
// Two-entry valid/ready buffer for received bytes
`timescale 1ns/1ps
module ssp_buf2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;

    wire push = in_valid_i && in_ready_o;
    wire pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (count != (PW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];

    // ========================================================================
    // Storage and pointers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data_i;
                wr_ptr      <= wr_ptr + PW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + PW'(1);
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

endmodule : ssp_buf2

// [ssp_chk.sv]
// Concurrent checks on the serial slave port outputs
`timescale 1ns/1ps
module ssp_chk
    import ssp_pkg::*;
(
    // Clocks and reset
    input wire logic       ref_clk_i,
    input wire logic       rstn_i,
    input wire logic       sclk_i,
    input wire logic       ss_n_i,
    // Writes and sources
    input wire logic [7:0] wdata_i,
    input wire logic       link_ctl_we_i,
    input wire logic       gpout_we_i,
    input wire logic       irq_request_i,
    input wire logic       rx_ready_i,
    // Observed outputs
    input wire logic       mosi_o,
    input wire logic       mosi_oe_o,
    input wire logic       miso_o,
    input wire logic       miso_oe_o,
    input ssp_pin_ctl_s    pin_control_o,
    input wire logic [7:0] bus_link_control_o,
    input wire logic       chip_clear_active_o,
    input wire logic       irq_o,
    input wire logic       irq_oe_o,
    input wire logic [7:0] general_outputs_o,
    input wire logic [7:0] rx_data_o,
    input wire logic       rx_valid_o,
    input wire logic       rx_overrun_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    // ========================================================================
    // Sequences
    // Two quiet cycles tolerate one stage of lag in the interrupt path
    sequence s_req_quiet;
        !irq_request_i ##1 !irq_request_i && $stable(pin_control_o);
    endsequence
    sequence s_clear_held;
        chip_clear_active_o ##1 chip_clear_active_o;
    endsequence

    // ========================================================================
    // Pins
    AST_DESEL_FLOAT:
    assert property (ss_n_i |-> !miso_oe_o && !mosi_oe_o)
        else $error("data pin driven while deselected");
    AST_HALF_MISO_OFF:
    assert property (pin_control_o.half_duplex |-> !$past(miso_oe_o))
        else $error("miso driven in half duplex");
    AST_FULL_MISO_ON:
    assert property (!pin_control_o.half_duplex && !$past(ss_n_i)
                     |-> $past(miso_oe_o))
        else $error("miso not driven while selected");
    AST_MOSI_EXCL:
    assert property (mosi_oe_o |-> !ss_n_i && !miso_oe_o)
        else $error("mosi driven out of half duplex frame");
    AST_TX_ON_FALL:
    assert property (!ss_n_i && $rose(sclk_i)
                     |-> $stable(miso_o) && $stable(mosi_o))
        else $error("data out changed at serial rising edge");

    // ========================================================================
    // Interrupt, control bytes, stream
    AST_EDGE_IRQ:
    assert property (pin_control_o.irq_edge_mode && $stable(pin_control_o)
                     |-> irq_oe_o)
        else $error("edge mode interrupt not push-pull");
    AST_EDGE_IDLE:
    assert property (s_req_quiet ##0 pin_control_o.irq_edge_mode
                     |-> irq_o == !pin_control_o.irq_polarity)
        else $error("edge interrupt active without request");
    AST_LEVEL_LOW:
    assert property (!pin_control_o.irq_edge_mode && $stable(pin_control_o)
                     |-> !irq_o)
        else $error("level interrupt drives high");
    AST_LEVEL_IDLE:
    assert property (s_req_quiet ##0 !pin_control_o.irq_edge_mode
                     |-> !irq_oe_o)
        else $error("level interrupt pulled without request");
    AST_GPOUT_WRITE:
    assert property (gpout_we_i ##1 !gpout_we_i && !chip_clear_active_o
                     ##1 !chip_clear_active_o
                     |-> general_outputs_o == $past(wdata_i, 2))
        else $error("general outputs miss written value");
    AST_LINK_WRITE:
    assert property (link_ctl_we_i ##1 !link_ctl_we_i
                     |-> ##1 bus_link_control_o == $past(wdata_i, 2))
        else $error("link control misses written value");
    AST_CLEAR_GPOUT:
    assert property (s_clear_held |-> general_outputs_o == GPOUT_RST)
        else $error("general outputs kept during chip clear");
    AST_RX_HOLD:
    assert property (rx_valid_o && !rx_ready_i
                     |=> rx_valid_o && $stable(rx_data_o))
        else $error("received byte dropped while stalled");
    AST_OVERRUN_FULL:
    assert property (rx_overrun_o |-> rx_valid_o)
        else $error("overrun with buffer not full");
endmodule : ssp_chk

bind ssp_top ssp_chk u_chk (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .sclk_i(sclk_i),
    .ss_n_i(ss_n_i), .wdata_i(wdata_i), .link_ctl_we_i(link_ctl_we_i),
    .gpout_we_i(gpout_we_i), .irq_request_i(irq_request_i),
    .rx_ready_i(rx_ready_i), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o),
    .miso_o(miso_o), .miso_oe_o(miso_oe_o), .pin_control_o(pin_control_o),
    .bus_link_control_o(bus_link_control_o),
    .chip_clear_active_o(chip_clear_active_o), .irq_o(irq_o),
    .irq_oe_o(irq_oe_o), .general_outputs_o(general_outputs_o),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
    .rx_overrun_o(rx_overrun_o)
);

// [ssp_spi_master.sv]
// Behavioural serial master that frames transfers on the select line
`timescale 1ns/1ps
module ssp_spi_master (
    // Master pins
    output logic      sclk_o,
    output logic      ss_n_o,
    output logic      mosi_w_o,
    // Device pins
    input wire logic  mosi_i,
    input wire logic  mosi_oe_i,
    input wire logic  miso_i,
    input wire logic  miso_oe_i
);
    // ========================================================================
    // Wire levels
    localparam int HALF = 32; // 15.6 MHz, below the 26 MHz ceiling
    logic m_oe;
    logic m_val;
    logic junk;
    // No pull on either data line: a floating line shows a toggling pattern
    assign mosi_w_o = mosi_oe_i ? mosi_i : (m_oe ? m_val : junk);

    initial begin
        {sclk_o, ss_n_o, m_oe, m_val, junk} = 5'b01100;
    end

    // ========================================================================
    // Frame: clock stands still outside frames
    task automatic frame(input logic [15:0] dout, input int n,
                         input logic sel, half, output logic [15:0] din);
        din = 16'h0000;
        #7;
        ss_n_o = ~sel;
        m_oe = ~half;
        for (int i = 0; i < n; i++) begin
            m_val = dout[15-i];
            junk = ~junk;
            #HALF;
            sclk_o = 1'b1;
            din = {din[14:0], half ? mosi_w_o : (miso_oe_i ? miso_i : junk)};
            #HALF;
            sclk_o = 1'b0;
        end
        #HALF;
        ss_n_o = 1'b1;
        m_oe = 1'b1;
    endtask : frame
endmodule : ssp_spi_master

// [test_ssp_top.sv]
// Directed testbench for the serial slave port and pin logic
`timescale 1ns/1ps
module test_ssp_top import ssp_pkg::*; ;
    // ========================================================================
    // Signals
    logic         clk, rstn, clr_n, irq_req, rx_rdy, tx_v, ovr_seen, act;
    logic [4:0]   we, src;
    logic [7:0]   wd, link, gpo, rxd;
    logic [8:0]   txw;
    logic [15:0]  din;
    logic         mosi_d, mosi_oe, miso, miso_oe, clr_act, mux_o;
    logic         irq, irq_oe, rx_v, ovr, tx_rdy, sclk, ss_n, mosi_w;
    ssp_pin_ctl_s pctl;
    int           num_errors, cmp_count;

    ssp_top uut (
        .ref_clk_i(clk), .rstn_i(rstn), .chip_clear_in_n_i(clr_n),
        .sclk_i(sclk), .ss_n_i(ss_n), .mosi_i(mosi_w),
        .mosi_o(mosi_d), .mosi_oe_o(mosi_oe), .miso_o(miso),
        .miso_oe_o(miso_oe), .wdata_i(wd), .pin_ctl_we_i(we[0]),
        .link_ctl_we_i(we[1]), .cpu_ctl_we_i(we[2]), .mode_we_i(we[3]),
        .gpout_we_i(we[4]), .pin_control_o(pctl),
        .bus_link_control_o(link), .chip_clear_active_o(clr_act),
        .irq_request_i(irq_req), .mux_src_i(src),
        .multiplexed_out_o(mux_o), .irq_o(irq), .irq_oe_o(irq_oe),
        .general_outputs_o(gpo), .rx_data_o(rxd), .rx_valid_o(rx_v),
        .rx_ready_i(rx_rdy), .rx_overrun_o(ovr), .tx_word_i(txw),
        .tx_valid_i(tx_v), .tx_ready_o(tx_rdy)
    );
    ssp_spi_master m (
        .sclk_o(sclk), .ss_n_o(ss_n), .mosi_w_o(mosi_w), .mosi_i(mosi_d),
        .mosi_oe_i(mosi_oe), .miso_i(miso), .miso_oe_i(miso_oe)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Overrun is a one-cycle pulse, so it is caught in a sticky flag
    always @(posedge clk) if (ovr === 1'b1) ovr_seen <= 1'b1;

    // ========================================================================
    // Tasks
    task automatic chk(input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    task automatic hang();
        num_errors++;
        $display("[FAIL] %0t: wait ran out", $time);
        give_verdict();
    endtask : hang
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask : w
    task automatic wr(input int k, input logic [7:0] d);
        @(posedge clk);
        wd <= d;
        we <= 5'h01 << k;
        @(posedge clk);
        we <= 5'h00;
        w(3);
    endtask : wr
    task automatic tx_load(input logic [8:0] t);
        int i;
        @(posedge clk);
        txw <= t;
        tx_v <= 1'b1;
        for (i = 0; i < 500; i++) begin
            @(negedge clk);
            if (tx_rdy === 1'b1) break;
        end
        if (i == 500) hang();
        @(posedge clk);
        tx_v <= 1'b0;
        w(10);
    endtask : tx_load
    task automatic rx_get(input logic [7:0] e);
        int i;
        for (i = 0; i < 500; i++) begin
            @(negedge clk);
            if (rx_v === 1'b1) break;
        end
        if (i == 500) hang();
        chk(rxd, e);
        @(posedge clk);
        rx_rdy <= 1'b1;
        @(posedge clk);
        rx_rdy <= 1'b0;
    endtask : rx_get

    // ========================================================================
    // Sequence
    initial begin
        {clr_n, irq_req, rx_rdy, tx_v, ovr_seen, rstn} = 6'h20;
        {we, src, wd, txw} = 27'h0;
        {num_errors, cmp_count} = 64'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        w(2);
        chk({tx_rdy, miso, rx_v, gpo, pctl}, {3'h6, 8'h00, 5'h00});
        wr(4, 8'ha5);
        wr(4, 8'h5a);
        chk(gpo, 8'h5a);
        wr(1, 8'h3c);
        chk(link, 8'h3c);
        // Four select codes, then the split select bit
        for (int k = 0; k < 5; k++) begin
            wr(k < 4 ? 0 : 3, k < 4 ? 8'(k) : 8'h01);
            for (int v = 0; v < 2; v++) begin
                @(posedge clk);
                src <= v ? ~(5'h01 << k) : 5'h01 << k;
                w(3);
                chk(mux_o, !v);
            end
        end
        // Every enable, request, mode and polarity combination
        for (int i = 0; i < 16; i++) begin
            wr(2, 8'(i[3]));
            wr(0, 8'(i[1:0]) << 2);
            @(posedge clk);
            irq_req <= i[2];
            w(3);
            act = i[3] & i[2];
            chk({irq_oe, irq}, i[1] ? {1'b1, act ~^ i[0]} : {act, 1'b0});
        end
        wr(0, 8'h00);
        tx_load(9'h03c);
        m.frame(16'ha55a, 16, 1'b1, 1'b0, din);
        chk(din, 16'h3c3c);
        m.frame(16'h0f00, 8, 1'b1, 1'b0, din);
        w(10);
        chk(ovr_seen, 1'b1);
        rx_get(8'ha5);
        rx_get(8'h5a);
        w(10);
        chk(rx_v, 1'b0);
        m.frame(16'hffff, 5, 1'b1, 1'b0, din);
        m.frame(16'h8100, 8, 1'b1, 1'b0, din);
        rx_get(8'h81);
        m.frame(16'h5500, 8, 1'b0, 1'b0, din);
        w(20);
        chk(rx_v, 1'b0);
        wr(0, 8'h10);
        tx_load(9'h1c3);
        m.frame(16'h0000, 8, 1'b1, 1'b1, din);
        chk(din[7:0], 8'hc3);
        // Chip clear keeps pin and link control, clears the rest
        wr(2, 8'h01);
        wr(3, 8'h01);
        wr(4, 8'h77);
        wr(0, 8'h08);
        @(posedge clk);
        {irq_req, src} <= 6'h30;
        w(3);
        chk({mux_o, irq}, 2'b10);
        @(posedge clk);
        clr_n <= 1'b0;
        w(6);
        chk({clr_act, gpo}, {1'b1, 8'h00});
        wr(4, 8'hff);
        chk(gpo, 8'h00);
        @(posedge clk);
        clr_n <= 1'b1;
        w(6);
        chk({clr_act, gpo, link, pctl}, {9'h000, 8'h3c, 5'h08});
        chk({mux_o, irq}, 2'b01);
        give_verdict();
    end
endmodule : test_ssp_top
